// [hw/tcu_pkg.sv]
package tcu_pkg;
   localparam int CNT_W       = 16;
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 32;
   localparam int TIMERS      = 3;
   localparam int PIN_TIMERS  = 2;
   localparam int SYNC_STAGES = 3;

   // Address layout: byte offset = {timer, register, 2'b00}
   localparam int TMR_HI = 5;
   localparam int TMR_LO = 4;
   localparam int REG_HI = 3;
   localparam int REG_LO = 2;

   localparam logic [1:0] REG_COUNT   = 2'h0;
   localparam logic [1:0] REG_LIMIT_A = 2'h1;
   localparam logic [1:0] REG_LIMIT_B = 2'h2;
   localparam logic [1:0] REG_CTRL    = 2'h3;
   localparam logic [1:0] TMR_0       = 2'h0;
   localparam logic [1:0] TMR_1       = 2'h1;
   localparam logic [1:0] TMR_2       = 2'h2;
   localparam logic [1:0] TMR_NONE    = 2'h3;
   localparam logic [1:0] BYTE_OFS    = 2'h0;
   localparam logic [1:0] PAGE_TOP    = 2'h0;

   localparam int GUARD_BIT = 9;

   localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] LIMIT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] LIMIT_WRAP  = 16'h0000;
   localparam logic [CNT_W:0]   FULL_SPAN   = 17'h1_0000;
   localparam logic [CNT_W:0]   ONE_STEP    = 17'h0_0001;

   typedef struct packed {
      logic irq_en;
      logic active_b;
      logic hit;
      logic restart;
      logic chain;
      logic pin_clk;
      logic two_limit;
      logic repeat_run;
      logic enable;
   } tcu_ctrl_t;

   localparam int CTRL_W = $bits(tcu_ctrl_t);
   localparam tcu_ctrl_t CTRL_RESET = '0;
   localparam tcu_ctrl_t T2_CTRL_MASK = '{irq_en: 1'b1, active_b: 1'b0,
      hit: 1'b1, restart: 1'b0, chain: 1'b0, pin_clk: 1'b0,
      two_limit: 1'b0, repeat_run: 1'b1, enable: 1'b1};

   typedef enum logic [1:0] {SLOT_T0, SLOT_T1, SLOT_T2, SLOT_IDLE} tcu_slot_t;

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             hit;
      logic             use_b;
      logic             seq_end;
   } tcu_svc_t;

   function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
      reg_mapped = addr[ADDR_W-1:TMR_HI+1] == PAGE_TOP
         && addr[REG_LO-1:0] == BYTE_OFS
         && addr[TMR_HI:TMR_LO] != TMR_NONE
         && !(addr[TMR_HI:TMR_LO] == TMR_2
              && addr[REG_HI:REG_LO] == REG_LIMIT_B);
   endfunction : reg_mapped
endpackage : tcu_pkg

// [hw/tcu_pin_sync.sv]
module tcu_pin_sync #(
   parameter int WIDTH = tcu_pkg::PIN_TIMERS
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o,
   output logic      [WIDTH-1:0] rise_o
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   wire  [WIDTH-1:0] agree = ~(s2 ^ s3);
   wire  [WIDTH-1:0] next_level = (agree & s3) | (~agree & level_o);

   // Level only moves once the two late stages agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1      <= '0;
         s2      <= '0;
         s3      <= '0;
         level_o <= '0;
         rise_o  <= '0;
      end else begin
         s1      <= pin_i;
         s2      <= s1;
         s3      <= s2;
         level_o <= next_level;
         rise_o  <= next_level & ~level_o;
      end
   end
endmodule : tcu_pin_sync

// [hw/tcu_slot_update.sv]
module tcu_slot_update #(
   parameter int CNT_W = tcu_pkg::CNT_W
) (
   input  wire logic [CNT_W-1:0] count_i,
   input  wire logic [CNT_W-1:0] limit_a_i,
   input  wire logic [CNT_W-1:0] limit_b_i,
   input  wire logic             use_b_i,
   input  wire logic             dual_i,
   input  wire logic             tick_i,
   input  wire logic             restart_i,
   output tcu_pkg::tcu_svc_t     result_o
);
   function automatic logic [CNT_W:0] span(input logic [CNT_W-1:0] lim);
      span = (lim == tcu_pkg::LIMIT_WRAP) ? tcu_pkg::FULL_SPAN
                                          : {1'b0, lim};
   endfunction : span

   wire              sel_b = dual_i & use_b_i;
   wire  [CNT_W-1:0] limit = sel_b ? limit_b_i : limit_a_i;
   wire  [CNT_W:0]   inc   = {1'b0, count_i} + tcu_pkg::ONE_STEP;
   // Only equality counts; a count past the limit runs on and wraps
   wire              hit   = tick_i & (inc == span(limit));

   // Increment, compare and clear in one step: the limit never lands
   assign result_o.count = (restart_i | hit) ? tcu_pkg::COUNT_RESET
                         : tick_i ? inc[CNT_W-1:0] : count_i;
   assign result_o.hit     = hit;
   assign result_o.use_b   = dual_i & (use_b_i ^ hit);
   assign result_o.seq_end = hit & (~dual_i | use_b_i);
endmodule : tcu_slot_update

// [hw/tcu_timer_unit.sv]
module tcu_timer_unit (
   input  wire logic                          CLK_SYS_I,
   input  wire logic                          RST_I,
   input  wire logic                          PSEL_I,
   input  wire logic                          PENABLE_I,
   input  wire logic                          PWRITE_I,
   input  wire logic [tcu_pkg::ADDR_W-1:0]    PADDR_I,
   input  wire logic [tcu_pkg::DATA_W-1:0]    PWDATA_I,
   input  wire logic [tcu_pkg::PIN_TIMERS-1:0] TMR_IN_I,
   output logic      [tcu_pkg::DATA_W-1:0]    PRDATA_O,
   output logic                               PREADY_O,
   output logic                               PSLVERR_O,
   output logic      [tcu_pkg::TIMERS-1:0]    TMR_IRQ_O
);
   localparam int CNT_W  = tcu_pkg::CNT_W;
   localparam int DATA_W = tcu_pkg::DATA_W;
   localparam int TIMERS = tcu_pkg::TIMERS;
   localparam int PINS   = tcu_pkg::PIN_TIMERS;

   function automatic logic [TIMERS-1:0] onehot(input logic [1:0] idx,
                                                input logic       en);
      onehot = '0;
      if (en && idx != tcu_pkg::TMR_NONE) begin
         onehot[idx] = 1'b1;
      end
   endfunction : onehot

   tcu_pkg::tcu_slot_t slot;
   tcu_pkg::tcu_slot_t next_slot;

   logic [CNT_W-1:0]   count [TIMERS];
   logic [CNT_W-1:0]   lim_a [TIMERS];
   logic [CNT_W-1:0]   lim_b [PINS];
   tcu_pkg::tcu_ctrl_t ctrl  [TIMERS];
   logic [PINS-1:0]    edge_seen;
   logic [PINS-1:0]    armed;
   logic [PINS-1:0]    t2_due;
   logic [PINS-1:0]    pin_lvl;
   logic [PINS-1:0]    pin_rise;
   tcu_pkg::tcu_svc_t  svc;

   // Shared counter element sequencing
   always_comb begin
      case (slot)
         tcu_pkg::SLOT_T0: next_slot = tcu_pkg::SLOT_T1;
         tcu_pkg::SLOT_T1: next_slot = tcu_pkg::SLOT_T2;
         tcu_pkg::SLOT_T2: next_slot = tcu_pkg::SLOT_IDLE;
         default:          next_slot = tcu_pkg::SLOT_T0;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         slot <= tcu_pkg::SLOT_IDLE;
      end else begin
         slot <= next_slot;
      end
   end

   tcu_pin_sync #(
      .WIDTH (PINS)
   ) u_pin_sync (
      .clk_i   (CLK_SYS_I),
      .rst_i   (RST_I),
      .pin_i   (TMR_IN_I),
      .level_o (pin_lvl),
      .rise_o  (pin_rise)
   );

   // Selection of the timer in service
   wire       servicing = slot != tcu_pkg::SLOT_IDLE;
   wire [1:0] sel       = servicing ? 2'(slot) : tcu_pkg::TMR_2;
   wire       is_pin    = sel != tcu_pkg::TMR_2;
   wire       pi        = sel[0];
   wire [TIMERS-1:0] serve    = onehot(sel, servicing);
   wire tcu_pkg::tcu_ctrl_t c = ctrl[sel];

   // Clock source and gating
   wire ext_mode   = is_pin & c.pin_clk;
   wire chain_mode = is_pin & ~c.pin_clk & c.chain;
   wire int_gated  = is_pin & ~c.pin_clk;
   wire src_ok     = ext_mode ? edge_seen[pi]
                   : chain_mode ? t2_due[pi] : 1'b1;
   // Restart mode waits for the first edge; otherwise pin is a level gate
   wire gate_ok    = !int_gated ? 1'b1
                   : c.restart ? armed[pi] : pin_lvl[pi];
   wire retrig     = int_gated & c.restart & edge_seen[pi] & c.enable;
   wire tick       = servicing & c.enable & src_ok & gate_ok & ~retrig;
   wire dual       = is_pin & c.two_limit;

   tcu_slot_update #(
      .CNT_W (CNT_W)
   ) u_slot_update (
      .count_i   (count[sel]),
      .limit_a_i (lim_a[sel]),
      .limit_b_i (lim_b[pi]),
      .use_b_i   (c.active_b),
      .dual_i    (dual),
      .tick_i    (tick),
      .restart_i (retrig),
      .result_o  (svc)
   );

   wire t2_hit_now = serve[tcu_pkg::TMR_2] & svc.hit;

   tcu_pkg::tcu_ctrl_t ctrl_svc;
   always_comb begin
      ctrl_svc          = c;
      ctrl_svc.hit      = c.hit | svc.hit;
      ctrl_svc.active_b = svc.use_b;
      ctrl_svc.enable   = c.enable & ~(svc.seq_end & ~c.repeat_run);
   end

   // Bus side: answers only in the idle slot, so no half-updated count
   wire       access  = PSEL_I & PENABLE_I & ~PREADY_O;
   wire       ans_now = access & (slot == tcu_pkg::SLOT_T2);
   wire       commit  = PSEL_I & PENABLE_I & PREADY_O;
   wire       mapped  = tcu_pkg::reg_mapped(PADDR_I);
   wire [1:0] a_tmr   = PADDR_I[tcu_pkg::TMR_HI:tcu_pkg::TMR_LO];
   wire [1:0] a_reg   = PADDR_I[tcu_pkg::REG_HI:tcu_pkg::REG_LO];
   wire [1:0] a_idx   = mapped ? a_tmr : tcu_pkg::TMR_2;
   wire       wr_go   = commit & PWRITE_I & mapped;
   wire       is_t2   = a_idx == tcu_pkg::TMR_2;
   wire       guard   = PWDATA_I[tcu_pkg::GUARD_BIT];

   wire tcu_pkg::tcu_ctrl_t wr_raw =
      tcu_pkg::tcu_ctrl_t'(PWDATA_I[tcu_pkg::CTRL_W-1:0]);
   wire tcu_pkg::tcu_ctrl_t old_ctrl = ctrl[a_idx];
   wire tcu_pkg::tcu_ctrl_t ctrl_mask =
      is_t2 ? tcu_pkg::T2_CTRL_MASK : '1;

   tcu_pkg::tcu_ctrl_t ctrl_wr;
   always_comb begin
      ctrl_wr          = wr_raw & ctrl_mask;
      ctrl_wr.active_b = old_ctrl.active_b;
      ctrl_wr.enable   = guard ? wr_raw.enable : old_ctrl.enable;
   end

   wire tcu_pkg::tcu_ctrl_t ctrl_rd = old_ctrl & ctrl_mask;
   wire [DATA_W-1:0] rd_word =
      !mapped ? '0
      : a_reg == tcu_pkg::REG_COUNT ?
         {{(DATA_W-CNT_W){1'b0}}, count[a_idx]}
      : a_reg == tcu_pkg::REG_LIMIT_A ?
         {{(DATA_W-CNT_W){1'b0}}, lim_a[a_idx]}
      : a_reg == tcu_pkg::REG_LIMIT_B ?
         {{(DATA_W-CNT_W){1'b0}}, lim_b[a_idx[0]]}
      : {{(DATA_W-tcu_pkg::CTRL_W){1'b0}}, ctrl_rd};

   // Bus writes land in the idle slot, service never does
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         for (int i = 0; i < TIMERS; i++) begin
            count[i] <= tcu_pkg::COUNT_RESET;
            lim_a[i] <= tcu_pkg::LIMIT_RESET;
            ctrl[i]  <= tcu_pkg::CTRL_RESET;
         end
         for (int i = 0; i < PINS; i++) begin
            lim_b[i] <= tcu_pkg::LIMIT_RESET;
         end
      end else if (wr_go) begin
         case (a_reg)
            tcu_pkg::REG_COUNT:   count[a_idx] <= PWDATA_I[CNT_W-1:0];
            tcu_pkg::REG_LIMIT_A: lim_a[a_idx] <= PWDATA_I[CNT_W-1:0];
            tcu_pkg::REG_LIMIT_B: lim_b[a_idx[0]] <= PWDATA_I[CNT_W-1:0];
            default:              ctrl[a_idx] <= ctrl_wr;
         endcase
      end else if (servicing) begin
         count[sel] <= svc.count;
         ctrl[sel]  <= ctrl_svc;
      end
   end

   // Pending events per pin timer; a new event beats the clear
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         edge_seen <= '0;
         armed     <= '0;
         t2_due    <= '0;
      end else begin
         for (int i = 0; i < PINS; i++) begin
            edge_seen[i] <= pin_rise[i] | (edge_seen[i] & ~serve[i]);
            armed[i]     <= ctrl[i].enable & (armed[i]
                            | (serve[i] & edge_seen[i]));
            t2_due[i]    <= t2_hit_now | (t2_due[i] & ~serve[i]);
         end
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= '0;
         TMR_IRQ_O <= '0;
      end else begin
         PREADY_O  <= ans_now;
         if (ans_now) begin
            PRDATA_O  <= rd_word;
            PSLVERR_O <= ~mapped;
         end
         TMR_IRQ_O <= serve & {TIMERS{svc.hit & c.irq_en}};
      end
   end

   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (RST_I);

   wire wr_ctrl0 = wr_go & a_reg == tcu_pkg::REG_CTRL & a_tmr == tcu_pkg::TMR_0;

   guard_hold_a: assert property (
      wr_ctrl0 && !guard |=> $stable(ctrl[0].enable))
      else $error("enable changed without guard bit");

   // Only control reads matter; a count or limit may well hold bit 9
   guard_read_a: assert property (
      PREADY_O && $past(a_reg == tcu_pkg::REG_CTRL && !PWRITE_I)
      |-> !PRDATA_O[tcu_pkg::GUARD_BIT])
      else $error("guard bit read back as one");

   irq_gate_a: assert property (
      TMR_IRQ_O[0] |-> $past(ctrl[0].irq_en) && ctrl[0].hit)
      else $error("request without irq enable or hit flag");

   hit_sticky_a: assert property (
      ctrl[1].hit && !(wr_go && a_tmr == tcu_pkg::TMR_1) |=> ctrl[1].hit)
      else $error("limit hit flag cleared by hardware");

   oneshot_stop_a: assert property (
      serve[2] && svc.seq_end && !c.repeat_run |=> !ctrl[2].enable)
      else $error("one-shot timer kept running");

   slot_order_a: assert property (
      slot == tcu_pkg::SLOT_T0 |=> slot == tcu_pkg::SLOT_T1
      ##1 slot == tcu_pkg::SLOT_T2 ##1 slot == tcu_pkg::SLOT_IDLE
      ##1 slot == tcu_pkg::SLOT_T0)
      else $error("service slots out of order");

   count_period_a: assert property (
      $changed(count[2]) && !$past(wr_go) |-> $past(slot) == tcu_pkg::SLOT_T2)
      else $error("timer 2 moved outside its slot");

   limit_clear_a: assert property (
      serve[0] && svc.hit && !wr_go |=> count[0] == tcu_pkg::COUNT_RESET)
      else $error("count not cleared at limit");

   hold_off_a: assert property (
      serve[1] && !ctrl[1].enable |=> $stable(count[1]))
      else $error("disabled timer changed count");

   answer_slot_a: assert property (
      access |-> ##[1:4] PREADY_O && $past(slot) == tcu_pkg::SLOT_T2)
      else $error("bus answer late or outside idle slot");

   chain_step_a: assert property (
      serve[0] && chain_mode && !ext_mode && tick |-> t2_due[0])
      else $error("prescaled step without timer 2 limit");

   dual_flip_a: assert property (
      serve[0] && dual && svc.hit |=> ctrl[0].active_b != $past(c.active_b))
      else $error("active limit did not alternate");

   count_step_a: assert property (
      serve[1] && tick && !svc.hit && !retrig |=>
      count[1] == CNT_W'({1'b0, $past(count[1])} + tcu_pkg::ONE_STEP))
      else $error("count did not advance by one");

   irq_off_a: assert property (
      serve[2] && !c.irq_en |=> !TMR_IRQ_O[2])
      else $error("request raised with irq enable clear");

   ext_edge_a: assert property (
      serve[1] && ext_mode && tick |-> edge_seen[1])
      else $error("pin clocked step without rising edge");

   level_gate_a: assert property (
      serve[0] && int_gated && !c.restart && !pin_lvl[0] |-> !tick)
      else $error("low pin did not stop internal counting");

   single_a_a: assert property (
      serve[0] && !c.two_limit && tick |=> !ctrl[0].active_b)
      else $error("single mode switched to limit B");

   t2_plain_a: assert property (
      !ctrl[2].pin_clk && !ctrl[2].chain && !ctrl[2].two_limit)
      else $error("timer 2 holds a pin, chain or dual bit");

   dual_hold_a: assert property (
      serve[1] && dual && svc.hit && !c.active_b |=> ctrl[1].enable
      || $past(wr_go))
      else $error("dual one-shot stopped after limit A");

   // Unmapped answers carry zero data so a stale word never leaks
   slverr_zero_a: assert property (
      PREADY_O && PSLVERR_O |-> PRDATA_O == '0)
      else $error("error answer carried read data");

   // Covers below show the main scenarios are reached at all
   wrap_cov: cover property (serve[2] && svc.hit && lim_a[2] == tcu_pkg::LIMIT_WRAP);
   dual_cov: cover property (serve[1] && dual && svc.seq_end);
   ext_cov:  cover property (serve[0] && ext_mode && tick);
   read_cov: cover property (commit && !PWRITE_I && mapped);
   chn_cov:  cover property (serve[1] && chain_mode && tick);
endmodule : tcu_timer_unit

// [bench/tcu_pin_model.sv]
module tcu_pin_model (
   input  wire logic       clk_i,
   input  wire logic [1:0] level_i,
   input  wire logic [1:0] pulse_i,
   output logic      [1:0] pin_o,
   output logic      [7:0] edges_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] phase = 3'h0;
   logic [1:0] arm   = 2'b00;
   logic [1:0] prev  = 2'b00;
   initial edges_o = 8'h00;
   // Whole pulses only, one rising edge per 8 clocks
   always @(posedge clk_i) begin
      phase <= phase + 3'h1;
      if (phase == 3'h0) begin
         arm <= pulse_i;
      end
      prev <= pin_o;
      if (pin_o[0] && !prev[0]) begin
         edges_o <= edges_o + 8'h01;
      end
   end
   assign pin_o = level_i | (arm & {2{phase[2]}});
endmodule : tcu_pin_model

// [bench/test_three_timer_counter_unit.sv]
module test_three_timer_counter_unit;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] EN   = 32'h0000_0001;
   localparam logic [31:0] REP  = 32'h0000_0002;
   localparam logic [31:0] TWO  = 32'h0000_0004;
   localparam logic [31:0] PIN  = 32'h0000_0008;
   localparam logic [31:0] CHN  = 32'h0000_0010;
   localparam logic [31:0] HIT  = 32'h0000_0040;
   localparam logic [31:0] ACTB = 32'h0000_0080;
   localparam logic [31:0] IRQ  = 32'h0000_0100;
   localparam logic [31:0] GRD  = 32'h0000_0200;
   localparam logic [31:0] Z    = 32'h0000_0000;
   logic        clk_sys = 1'b0;
   logic        rst     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [1:0]  level   = 2'b11;
   logic [1:0]  pulse   = 2'b00;
   logic [1:0]  pins;
   logic [7:0]  edges;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [31:0] c1;
   logic        pready;
   logic        pslverr;
   logic        er;
   logic [2:0]  irq;
   int          irq_cnt [3];
   int          cycles, t_ans, t1, b, miscompares, compares;
   logic [15:0] st [3] = '{16'h0000, 16'hFFF8, 16'hFFF8};
   logic [15:0] lm [3] = '{16'h0005, 16'h0002, 16'h0000};
   int          ev [3] = '{5, 10, 8};

   tcu_timer_unit i_tcu_timer_unit (
      .CLK_SYS_I (clk_sys),
      .RST_I     (rst),
      .PSEL_I    (psel),
      .PENABLE_I (penable),
      .PWRITE_I  (pwrite),
      .PADDR_I   (paddr),
      .PWDATA_I  (pwdata),
      .TMR_IN_I  (pins),
      .PRDATA_O  (prdata),
      .PREADY_O  (pready),
      .PSLVERR_O (pslverr),
      .TMR_IRQ_O (irq)
   );
   tcu_pin_model i_tcu_pin_model (
      .clk_i   (clk_sys),
      .level_i (level),
      .pulse_i (pulse),
      .pin_o   (pins),
      .edges_o (edges)
   );

   always #5 clk_sys = ~clk_sys;

   task automatic conclude;
      if (miscompares == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   // Cycle stamps, irq pulse tally and hang guard
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      for (int i = 0; i < 3; i++) begin
         irq_cnt[i] <= irq_cnt[i] + int'(irq[i] === 1'b1);
      end
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Entered just after a rising edge; leaves one edge after release
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd    = prdata;
      er    = pslverr;
      t_ans = cycles;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, Z);
      chk(rd, exp);
   endtask : rdchk

   task automatic prog(input logic [7:0] a, input logic [31:0] c, la, lb,
                       input logic [31:0] ctl);
      wr(a, c);
      wr(a + 8'h04, la);
      if (a != 8'h20) begin
         wr(a + 8'h08, lb);
      end
      wr(a + 8'h0C, ctl | GRD);
   endtask : prog

   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rdchk(8'h0C, Z);
      wr(8'h0C, EN | REP);
      rdchk(8'h0C, REP);
      wr(8'h0C, EN | REP | GRD);
      rdchk(8'h0C, EN | REP);
      wr(8'h0C, GRD);
      // Timer 2 drops pin, chain and two-limit bits
      wr(8'h2C, 32'h0000_01FE);
      rdchk(8'h2C, 32'h0000_0142);
      wr(8'h2C, GRD);
      xfer(1'b0, 8'h28, Z);
      chk(er, 1'b1);
      chk(rd, Z);
      xfer(1'b1, 8'h30, 32'h0000_FFFF);
      chk(er, 1'b1);
      // Idle-slot reads are a whole number of 4-clock rounds apart
      prog(8'h00, Z, Z, Z, EN | REP);
      xfer(1'b0, 8'h00, Z);
      t1 = t_ans;
      c1 = rd;
      repeat (9) @(posedge clk_sys);
      xfer(1'b0, 8'h00, Z);
      chk(rd - c1, 32'((t_ans - t1) / 4));
      // One-shot: plain limit, count above limit, limit zero
      wr(8'h0C, GRD);
      for (int k = 0; k < 3; k++) begin
         b = irq_cnt[0];
         prog(8'h00, {16'h0000, st[k]}, {16'h0000, lm[k]}, Z, IRQ | EN);
         repeat (ev[k] * 4 - 14) @(posedge clk_sys);
         rdchk(8'h0C, IRQ | EN);
         repeat (30) @(posedge clk_sys);
         rdchk(8'h0C, IRQ | HIT);
         rdchk(8'h00, Z);
         chk(irq_cnt[0] - b, 1);
      end
      wr(8'h0C, GRD);
      rdchk(8'h0C, Z);
      // Dual limits on timer 1, one-shot
      b = irq_cnt[1];
      rd = Z;
      prog(8'h10, Z, 32'h0000_0002, 32'h0000_0005, TWO | IRQ | EN);
      for (int k = 0; k < 10 && rd[6] !== 1'b1; k++) begin
         xfer(1'b0, 8'h1C, Z);
      end
      chk(rd, TWO | IRQ | EN | HIT | ACTB);
      repeat (40) @(posedge clk_sys);
      rdchk(8'h1C, TWO | IRQ | HIT);
      chk(irq_cnt[1] - b, 2);
      // Low pin gates internal counting; disabled timer holds
      level <= 2'b00;
      prog(8'h10, Z, Z, Z, EN | REP);
      prog(8'h20, 32'h0000_0007, Z, Z, Z);
      repeat (40) @(posedge clk_sys);
      rdchk(8'h10, Z);
      rdchk(8'h20, 32'h0000_0007);
      wr(8'h1C, GRD);
      // Pin clocking counts rising edges only
      prog(8'h00, Z, Z, Z, PIN | REP | EN);
      c1 = {24'h00_0000, edges};
      pulse <= 2'b01;
      repeat (60) @(posedge clk_sys);
      pulse <= 2'b00;
      repeat (20) @(posedge clk_sys);
      rdchk(8'h00, {24'h00_0000, edges} - c1);
      // Prescale by timer 2, enabled last
      wr(8'h0C, GRD);
      level <= 2'b11;
      prog(8'h00, Z, Z, Z, CHN | REP | EN);
      b = irq_cnt[2];
      prog(8'h20, Z, 32'h0000_0003, Z, IRQ | REP | EN);
      repeat (100) @(posedge clk_sys);
      wr(8'h2C, GRD);
      repeat (20) @(posedge clk_sys);
      rdchk(8'h00, 32'(irq_cnt[2] - b));
      conclude();
   end
endmodule : test_three_timer_counter_unit
